//--- hdl/pfrw_regs.svh
`ifndef PFRW_REGS_SVH
`define PFRW_REGS_SVH

// Latch and row addressing and erased cell value
`define PFRW_LATCH_ABITS   6
`define PFRW_ROW_BITS      4
`define PFRW_ERASED_BYTE   8'hff

// Clock period and internal operation times
`define PFRW_CLK_NS        50
`define PFRW_ERASE_TIME_US 2000
`define PFRW_PROG_TIME_US  2000
`define PFRW_ERASE_CYCLES  ((`PFRW_ERASE_TIME_US * 1000) / `PFRW_CLK_NS)
`define PFRW_PROG_CYCLES   ((`PFRW_PROG_TIME_US * 1000) / `PFRW_CLK_NS)

`endif

//--- hdl/pfrw_pkg.sv
package pfrw_pkg;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_TIME  = 3'b010,
        ST_SWEEP = 3'b100
    } pfrw_state_type;

    // Command codes on the command port
    typedef enum logic [1:0] {
        OP_ERASE = 2'h0,
        OP_PROG  = 2'h1,
        OP_BULK  = 2'h2,
        OP_NONE  = 2'h3
    } pfrw_op_type;

endpackage

//--- hdl/pfrw_flash_row_writer.sv
`timescale 1ns/1ns
`include "pfrw_regs.svh"
// Operation
// R1 - Reads, erases and programs are served while the device runs normally.
// R2 - Every read returns one byte.
// R3 - Erase and program act on a whole block of bytes, never one byte.
// R4 - A bulk erase coming from user code is refused.
// R5 - While an erase or program runs, all fetches and reads are held off.
// R6 - An internal timer ends each erase or program without software help.
// R7 - Any written value is stored unchecked; undecodable words run as no-ops in the core.
// R8 - The array is organised as 16-bit words grouped into rows.
// R9 - One row is the smallest region software can erase.
// R10 - After an erase, all or part of a row may be programmed.
// R11 - Row data is staged in 8-bit latches selected by 6 address bits.
// R12 - Latches are not addressable; each latch data write fills the next one.
// R13 - Unprogrammed cells can be programmed without erase, others stay intact.
// R14 - To alter part of a row, software saves it, erases, then reloads all latches.
// R15 - A program moves all latches into the addressed row as one timed operation.
module pfrw_flash_row_writer #(
    parameter int ROW_BITS     = `PFRW_ROW_BITS,
    parameter int ERASE_CYCLES = `PFRW_ERASE_CYCLES,
    parameter int PROG_CYCLES  = `PFRW_PROG_CYCLES
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Byte read and fetch port
    input  wire logic                  rdReq,
    input  wire logic [ROW_BITS+5:0]   rdAddr,
    output logic      [7:0]            rdData_ff,
    output logic                       rdValid_ff,
    // Table latch data writes
    input  wire logic                  latchWrEn,
    input  wire logic [7:0]            latchData,
    // Operation command
    input  wire logic                  cmdValid,
    input  wire logic [1:0]            cmdOp,
    input  wire logic [ROW_BITS-1:0]   cmdRow,
    input  wire logic                  cmdFromUser,
    // Status
    output logic                       busy_ff,
    output logic                       done_ff,
    output logic                       refused_ff
);

    localparam int LB    = `PFRW_LATCH_ABITS;
    localparam int AW    = ROW_BITS + LB;
    localparam int DEPTH = 1 << AW;
    localparam int NLAT  = 1 << LB;
    localparam int TW    = 24;

    // Array of bytes, two per 16-bit word, NLAT bytes per row; not reset
    logic [7:0] flashMem [DEPTH];                          // see R8
    // Write latches staged for the next program
    logic [7:0] latch_ff [NLAT];                            // see R11

    pfrw_pkg::pfrw_state_type state_ff;
    pfrw_pkg::pfrw_state_type nxt_state;
    pfrw_pkg::pfrw_op_type    op_ff;
    pfrw_pkg::pfrw_op_type    nxt_op;
    pfrw_pkg::pfrw_op_type    cmdCode;
    logic [TW-1:0]            timer_ff;
    logic [TW-1:0]            nxt_timer;
    logic [AW-1:0]            sweepAddr_ff;
    logic [AW-1:0]            nxt_sweepAddr;
    logic [AW-1:0]            sweepEnd_ff;
    logic [AW-1:0]            nxt_sweepEnd;
    logic [LB-1:0]            latchPtr_ff;
    logic [LB-1:0]            nxt_latchPtr;
    logic                     nxt_busy;
    logic                     nxt_done;
    logic                     nxt_refused;
    logic                     nxt_rdValid;
    logic [7:0]               nxt_rdData;
    logic                     accept;
    logic                     memWe;
    logic [7:0]               memWrData;
    logic [7:0]               sweepOld;
    logic                     latchWe;
    logic                     latchClr;

    assign cmdCode  = pfrw_pkg::pfrw_op_type'(cmdOp);
    assign sweepOld = flashMem[sweepAddr_ff];

    // Command acceptance and sequencer next state
    always_comb begin
        nxt_state     = state_ff;
        nxt_op        = op_ff;
        nxt_timer     = timer_ff;
        nxt_sweepAddr = sweepAddr_ff;
        nxt_sweepEnd  = sweepEnd_ff;
        nxt_done      = 1'b0;
        nxt_refused   = 1'b0;
        accept        = 1'b0;
        memWe         = 1'b0;
        memWrData     = `PFRW_ERASED_BYTE;
        latchClr      = 1'b0;
        unique case (state_ff)
            pfrw_pkg::ST_IDLE: begin
                if (cmdValid) begin
                    unique case (cmdCode)
                        pfrw_pkg::OP_ERASE,
                        pfrw_pkg::OP_PROG: begin
                            accept        = 1'b1;              // see R1
                            nxt_sweepAddr = {cmdRow, {LB{1'b0}}};  // see R3 R9
                            nxt_sweepEnd  = {cmdRow, {LB{1'b1}}};
                        end
                        pfrw_pkg::OP_BULK: begin
                            accept        = !cmdFromUser;      // see R4
                            nxt_refused   = cmdFromUser;       // see R4
                            nxt_sweepAddr = '0;
                            nxt_sweepEnd  = '1;
                        end
                        default: begin
                            nxt_refused = 1'b1;
                        end
                    endcase
                    if (accept) begin
                        nxt_op    = cmdCode;
                        nxt_state = pfrw_pkg::ST_TIME;
                        if (cmdCode == pfrw_pkg::OP_PROG) begin
                            nxt_timer = TW'(PROG_CYCLES - 1);   // see R6
                        end else begin
                            nxt_timer = TW'(ERASE_CYCLES - 1);  // see R6
                        end
                    end
                end
            end
            pfrw_pkg::ST_TIME: begin
                // Internal timer alone ends the wait
                if (timer_ff == '0) begin
                    nxt_state = pfrw_pkg::ST_SWEEP;            // see R6
                end else begin
                    nxt_timer = timer_ff - 1'b1;
                end
            end
            pfrw_pkg::ST_SWEEP: begin
                memWe = 1'b1;
                if (op_ff == pfrw_pkg::OP_PROG) begin
                    // Cells only fall from 1 to 0: erased cells take data
                    memWrData = sweepOld & latch_ff[sweepAddr_ff[LB-1:0]];  // see R13 R10 R7
                end
                if (sweepAddr_ff == sweepEnd_ff) begin
                    nxt_state = pfrw_pkg::ST_IDLE;
                    nxt_done  = 1'b1;
                    latchClr  = (op_ff == pfrw_pkg::OP_PROG);  // see R15
                end else begin
                    nxt_sweepAddr = sweepAddr_ff + 1'b1;       // see R15
                end
            end
        endcase
        nxt_busy = (nxt_state != pfrw_pkg::ST_IDLE);           // see R5
    end

    // Sequencer registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff     <= pfrw_pkg::ST_IDLE;
            op_ff        <= pfrw_pkg::OP_NONE;
            timer_ff     <= '0;
            sweepAddr_ff <= '0;
            sweepEnd_ff  <= '0;
            busy_ff      <= 1'b0;
            done_ff      <= 1'b0;
            refused_ff   <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            op_ff        <= nxt_op;
            timer_ff     <= nxt_timer;
            sweepAddr_ff <= nxt_sweepAddr;
            sweepEnd_ff  <= nxt_sweepEnd;
            busy_ff      <= nxt_busy;
            done_ff      <= nxt_done;
            refused_ff   <= nxt_refused;
        end
    end

    // Array cell update, one byte per sweep cycle
    always_ff @(posedge clk) begin
        if (memWe) begin
            flashMem[sweepAddr_ff] <= memWrData;               // see R7
        end
    end

    // Sequential latch loading; ignored while an operation runs
    always_comb begin
        latchWe      = latchWrEn && (state_ff == pfrw_pkg::ST_IDLE);
        nxt_latchPtr = latchPtr_ff;
        if (latchClr) begin
            nxt_latchPtr = '0;
        end else if (latchWe) begin
            nxt_latchPtr = latchPtr_ff + 1'b1;                 // see R12
        end
    end

    // Latch pointer register
    always_ff @(posedge clk) begin
        if (rst) begin
            latchPtr_ff <= '0;
        end else begin
            latchPtr_ff <= nxt_latchPtr;
        end
    end

    // Latches return to erased value after reset and after each program
    for (genvar i = 0; i < NLAT; i++) begin : g_latch
        always_ff @(posedge clk) begin
            if (rst || latchClr) begin
                latch_ff[i] <= `PFRW_ERASED_BYTE;
            end else if (latchWe && latchPtr_ff == LB'(i)) begin
                latch_ff[i] <= latchData;                      // see R12 R11
            end
        end
    end

    // Byte reads, held off while busy
    always_comb begin
        nxt_rdValid = rdReq && !busy_ff && (state_ff == pfrw_pkg::ST_IDLE);  // see R5
        nxt_rdData  = rdData_ff;
        if (nxt_rdValid) begin
            nxt_rdData = flashMem[rdAddr];                     // see R2
        end
    end

    // Read registers
    always_ff @(posedge clk) begin
        if (rst) begin
            rdValid_ff <= 1'b0;
            rdData_ff  <= 8'h00;
        end else begin
            rdValid_ff <= nxt_rdValid;
            rdData_ff  <= nxt_rdData;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence seq_accept;
        state_ff == pfrw_pkg::ST_IDLE && cmdValid && accept;
    endsequence

    sequence seq_held;
        busy_ff [*8];
    endsequence

    sequence seq_sweep_more;
        state_ff == pfrw_pkg::ST_SWEEP && sweepAddr_ff != sweepEnd_ff;
    endsequence

    // Read port checks
    chk_read_held_off: assert property (rdValid_ff |-> $past(rdReq) && !$past(busy_ff))  // see R5
        else $error("read answered while busy");
    chk_busy_blocks_read: assert property (busy_ff |=> !rdValid_ff)  // see R5
        else $error("read answered during operation");
    chk_read_data: assert property (rdValid_ff  // see R2
        |-> rdData_ff == flashMem[$past(rdAddr)])
        else $error("read byte differs from array");

    // Command and timer checks
    chk_bulk_user_refused: assert property (  // see R4
        state_ff == pfrw_pkg::ST_IDLE && cmdValid && cmdCode == pfrw_pkg::OP_BULK
        && cmdFromUser |=> refused_ff && !busy_ff)
        else $error("user bulk erase not refused");
    chk_refused_idle: assert property (refused_ff |-> !busy_ff && !done_ff)  // see R4
        else $error("refused command started an operation");
    chk_timed_hold: assert property (seq_accept |=> seq_held)  // see R6
        else $error("operation ended before timer");
    chk_done_clears_busy: assert property (done_ff |-> !busy_ff && $past(busy_ff))  // see R6
        else $error("done without end of busy");
    chk_done_pulse: assert property (done_ff |=> !done_ff)  // see R6
        else $error("done held for more than one cycle");

    // Array write checks
    chk_erase_value: assert property (  // see R9
        memWe && op_ff != pfrw_pkg::OP_PROG |-> memWrData == `PFRW_ERASED_BYTE)
        else $error("erase wrote non-erased value");
    chk_prog_merge: assert property (memWe && op_ff == pfrw_pkg::OP_PROG  // see R13
        |-> memWrData == (sweepOld & latch_ff[sweepAddr_ff[LB-1:0]]))
        else $error("program value not latch merge");
    chk_no_bit_rise: assert property (memWe && op_ff == pfrw_pkg::OP_PROG  // see R13
        |-> (memWrData & ~sweepOld) == 8'h00)
        else $error("program raised an array bit");
    chk_cell_lands: assert property (memWe  // see R7
        |=> flashMem[$past(sweepAddr_ff)] == $past(memWrData))
        else $error("array byte not stored");
    chk_sweep_step: assert property (seq_sweep_more  // see R15
        |=> state_ff == pfrw_pkg::ST_SWEEP && sweepAddr_ff == $past(sweepAddr_ff) + 1'b1)
        else $error("sweep skipped a byte");
    chk_row_bound: assert property (memWe && op_ff != pfrw_pkg::OP_BULK  // see R3
        |-> sweepAddr_ff[AW-1:LB] == sweepEnd_ff[AW-1:LB])
        else $error("sweep left the addressed row");

    // Latch checks
    chk_latch_step: assert property (latchWe && !latchClr  // see R12
        |=> latchPtr_ff == $past(latchPtr_ff) + 1'b1)
        else $error("latch pointer did not advance");
    chk_latch_frozen: assert property (latchWrEn && state_ff != pfrw_pkg::ST_IDLE  // see R12
        && !latchClr |=> latchPtr_ff == $past(latchPtr_ff))
        else $error("latch loaded during operation");
    chk_prog_clears: assert property (done_ff && $past(op_ff == pfrw_pkg::OP_PROG)  // see R15
        |-> latchPtr_ff == '0)
        else $error("latches not restarted after program");

endmodule

//--- verif/program_flash_row_writer_tb.sv
`timescale 1ns/1ns
module program_flash_row_writer_tb;
    localparam int ROWB = 4;
    localparam int TCYC = 16;

    // Design connections
    logic            clk;
    logic            rst;
    logic            rdReq;
    logic [ROWB+5:0] rdAddr;
    logic [7:0]      rdData_ff;
    logic            rdValid_ff;
    logic            latchWrEn;
    logic [7:0]      latchData;
    logic            cmdValid;
    logic [1:0]      cmdOp;
    logic [ROWB-1:0] cmdRow;
    logic            cmdFromUser;
    logic            busy_ff;
    logic            done_ff;
    logic            refused_ff;
    // Bench state
    int              fail_count;
    int              checks_done;
    int              cycleCount;
    int              opCycles;
    logic [7:0]      rowBuf [64];

    pfrw_flash_row_writer #(.ROW_BITS(ROWB), .ERASE_CYCLES(TCYC), .PROG_CYCLES(TCYC)) u_dut (
        .clk(clk), .rst(rst), .rdReq(rdReq), .rdAddr(rdAddr), .rdData_ff(rdData_ff),
        .rdValid_ff(rdValid_ff), .latchWrEn(latchWrEn), .latchData(latchData),
        .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdRow(cmdRow), .cmdFromUser(cmdFromUser),
        .busy_ff(busy_ff), .done_ff(done_ff), .refused_ff(refused_ff)
    );

    // Clock generator, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Closing report and verdict
    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 8000) begin
            fail_count++;
            test_done();
        end
    end

    // Compare one value against its expectation
    task automatic check(input logic [7:0] seen, input logic [7:0] expVal);
        checks_done++;
        if (seen !== expVal) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, expVal);
        end
    endtask

    // Back-to-back byte reads into rowBuf
    task automatic readBytes(input int base, input int n);
        @(negedge clk);
        rdReq  = 1'b1;
        rdAddr = base[ROWB+5:0];
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            check({7'h00, rdValid_ff}, 8'h01);
            rowBuf[i] = rdData_ff;
            if (i < n - 1) rdAddr = rdAddr + 1'b1;
            else rdReq = 1'b0;
        end
    endtask

    // Sequential latch loads, values seed+i
    task automatic loadLatches(input int n, input logic [7:0] seed);
        @(negedge clk);
        latchWrEn = 1'b1;
        for (int i = 0; i < n; i++) begin
            latchData = seed + i[7:0];
            @(negedge clk);
        end
        latchWrEn = 1'b0;
    endtask

    // Issue a command; while busy, hammer reads and latch writes that must be dropped
    task automatic runCmd(input logic [1:0] op, input logic [3:0] row, input logic user,
                          input logic accept, input int bytes);
        @(negedge clk);
        cmdValid = 1'b1;
        cmdOp = op;
        cmdRow = row;
        cmdFromUser = user;
        @(negedge clk);
        cmdValid = 1'b0;
        check({7'h00, busy_ff}, {7'h00, accept});
        check({7'h00, refused_ff}, {7'h00, ~accept});
        if (accept) begin
            opCycles = 0;
            rdReq = 1'b1;
            latchWrEn = 1'b1;
            latchData = 8'h00;
            while (done_ff !== 1'b1 && opCycles < TCYC + bytes + 20) begin
                @(negedge clk);
                opCycles++;
                if (busy_ff === 1'b1) check({7'h00, rdValid_ff}, 8'h00);
            end
            rdReq = 1'b0;
            latchWrEn = 1'b0;
            check({6'h00, done_ff, busy_ff}, 8'h02);
            check({7'h00, opCycles == TCYC + bytes}, 8'h01);
        end
    endtask

    // Erase rows 3 and 4, row 3 reads back blank
    task automatic scnErase();
        runCmd(pfrw_pkg::OP_ERASE, 4'h3, 1'b1, 1'b1, 64);
        runCmd(pfrw_pkg::OP_ERASE, 4'h4, 1'b1, 1'b1, 64);
        readBytes(192, 64);
        for (int i = 0; i < 64; i++) check(rowBuf[i], 8'hff);
    endtask

    // Partial row program, neighbour row untouched
    task automatic scnProgram();
        loadLatches(4, 8'h5a);
        runCmd(pfrw_pkg::OP_PROG, 4'h3, 1'b1, 1'b1, 64);
        readBytes(192, 6);
        for (int i = 0; i < 4; i++) check(rowBuf[i], 8'h5a + i[7:0]);
        check(rowBuf[4], 8'hff);
        readBytes(256, 1);
        check(rowBuf[0], 8'hff);
    endtask

    // Reprogram without erase; latches must have returned blank
    task automatic scnNoErase();
        loadLatches(1, 8'h0f);
        runCmd(pfrw_pkg::OP_PROG, 4'h3, 1'b1, 1'b1, 64);
        readBytes(192, 2);
        check(rowBuf[0], 8'h0a);
        check(rowBuf[1], 8'h5b);
    endtask

    // 65 loads wrap the pointer onto latch 0
    task automatic scnWrap();
        loadLatches(65, 8'h30);
        runCmd(pfrw_pkg::OP_PROG, 4'h4, 1'b1, 1'b1, 64);
        readBytes(256, 64);
        check(rowBuf[0], 8'h70);
        check(rowBuf[63], 8'h6f);
    endtask

    // Save a row, erase it, reload saved and new bytes, program again
    task automatic scnRewrite();
        readBytes(192, 64);
        rowBuf[1] = 8'ha5;
        runCmd(pfrw_pkg::OP_ERASE, 4'h3, 1'b1, 1'b1, 64);
        @(negedge clk);
        latchWrEn = 1'b1;
        for (int i = 0; i < 64; i++) begin
            latchData = rowBuf[i];
            @(negedge clk);
        end
        latchWrEn = 1'b0;
        runCmd(pfrw_pkg::OP_PROG, 4'h3, 1'b1, 1'b1, 64);
        readBytes(192, 3);
        check(rowBuf[0], 8'h0a);
        check(rowBuf[1], 8'ha5);
        check(rowBuf[2], 8'h5c);
    endtask

    // Refused commands, then a privileged bulk erase
    task automatic scnBulk();
        runCmd(pfrw_pkg::OP_BULK, 4'h0, 1'b1, 1'b0, 0);
        runCmd(pfrw_pkg::OP_NONE, 4'h0, 1'b0, 1'b0, 0);
        readBytes(192, 1);
        check(rowBuf[0], 8'h0a);
        runCmd(pfrw_pkg::OP_BULK, 4'h0, 1'b0, 1'b1, 1024);
        readBytes(256, 1);
        check(rowBuf[0], 8'hff);
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        rdReq = 1'b0;
        rdAddr = '0;
        latchWrEn = 1'b0;
        latchData = 8'h00;
        cmdValid = 1'b0;
        cmdOp = 2'h3;
        cmdRow = '0;
        cmdFromUser = 1'b0;
        fail_count = 0;
        checks_done = 0;
        cycleCount = 0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        check({4'h0, busy_ff, done_ff, refused_ff, rdValid_ff}, 8'h00);
        check(rdData_ff, 8'h00);
        scnErase();
        scnProgram();
        scnNoErase();
        scnRewrite();
        scnWrap();
        scnBulk();
        test_done();
    end
endmodule
